//--- verilog/swd_pkg.sv
// constants shared by both ends of the single-wire debug link
// assumes one system clock per end; the wire is resolved by the interface
package swd_pkg;
	localparam int BIT_CYCLES     = 16;
	localparam int TIMEOUT_CYCLES = 512;
	localparam int SAMPLE_CYCLE   = 10;
	localparam int ONE_PULSE_CYC  = 7;
	localparam int ZERO_LOW_CYC   = 13;
	localparam int HOST_LOW_CYC   = 2;
	localparam int HOST_SAMPLE    = 10;
	localparam int DELAY_SLOT_CYC = 16;
	localparam int SYNC_MIN_LOW   = 128;
	localparam int SYNC_RESP_CYC  = 128;
	localparam int CMD_BITS       = 8;
	localparam int CNT_W          = 10;
	// halted-only group: codes with bit 7 clear
	localparam int HALT_ONLY_BIT  = 7;
endpackage

//--- verilog/swd_link_if.sv
// wire of the debug link; resolves the pseudo-open-drain pin
// assumes each end drives only while its enable is high
interface swd_link_if;
	logic tgt_o;
	logic tgt_oe;
	logic host_o;
	logic host_oe;
	logic pin;
	logic host_reset;
	// on-chip pullup when nobody drives
	assign pin = (tgt_oe && !tgt_o) || (host_oe && !host_o) ? 1'b0 : 1'b1;
	modport target (input pin, input host_reset,
		output tgt_o, output tgt_oe);
	modport host (input pin, output host_o, output host_oe,
		output host_reset);
endinterface

//--- verilog/swd_target.sv
// target end: bit engine, command framing, sync answer, mode strap
// assumes the alternate clock enable comes from the same clock domain
// assumes the host keeps near the nominal sixteen-tick bit
module swd_target (
	input  wire logic CLK_SYS,
	input  wire logic RST,
	swd_link_if.target LINK,
	input  wire logic ALT_TICK,
	input  wire logic DEBUG_CLOCK_SELECT,
	input  wire logic CPU_HALTED,
	input  wire logic [7:0] TX_BYTE,
	output logic       BOOT_HALTED,
	output logic       CMD_VALID,
	output logic [7:0] CMD_CODE,
	output logic       CMD_REJECT,
	output logic       CMD_ABORT,
	output logic       RX_VALID,
	output logic [7:0] RX_BYTE
);
	typedef enum {IDLE, RXBIT, TXBIT, SYNC_WAIT, SYNC_RESP} swd_state_type;
	localparam logic [9:0] W = 10'h000;
	swd_state_type st_r;
	logic       s1_r, s2_r, prev_r;
	logic [9:0] cnt_r, idle_r;
	logic [2:0] bitn_r;
	logic [7:0] sh_r;
	logic       hdr_r, txmode_r, tbit_r;
	logic       rst_s1_r, rst_s2_r, rst_p_r, boot_r;
	logic       strap_rel;
	logic       timeout_hit;
	logic [7:0] rx_next;
	// one level in behind the msb-first byte, both directions
	function automatic logic [7:0] shift_in(input logic [7:0] v,
		input logic b);
		return {v[6:0], b};
	endfunction
	logic       tick;
	logic       fall;
	////////////////////////////////////////////////////////////////
	// pin sampling: two stages before any logic
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			prev_r <= 1'b1;
			// idle level, so no false release follows reset
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
			rst_p_r <= 1'b0;
		end else begin
			s1_r <= LINK.pin;
			s2_r <= s1_r;
			prev_r <= s2_r;
			rst_s1_r <= LINK.host_reset;
			rst_s2_r <= rst_s1_r;
			rst_p_r <= rst_s2_r;
		end
	end
	assign fall = prev_r && !s2_r;
	assign strap_rel = rst_p_r && !rst_s2_r;
	assign rx_next = shift_in(sh_r, s2_r);
	assign tick = DEBUG_CLOCK_SELECT ? ALT_TICK : 1'b1;
	////////////////////////////////////////////////////////////////
	// strap caught on release of host reset, not under async reset
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST)
			boot_r <= 1'b0;
		else if (strap_rel)
			boot_r <= !s2_r;
	end
	assign BOOT_HALTED = boot_r;
	////////////////////////////////////////////////////////////////
	// bit timeout: ticks since the last falling edge on the pin
	// saturates so a parked link never wraps into a second abort
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST)
			idle_r <= W;
		else if (fall)
			idle_r <= W;
		else if (tick && idle_r != 10'(swd_pkg::TIMEOUT_CYCLES))
			idle_r <= idle_r + 10'h001;
	end
	assign timeout_hit = tick
		&& idle_r == 10'(swd_pkg::TIMEOUT_CYCLES - 1);
	////////////////////////////////////////////////////////////////
	// bit engine; no reset of the target needed to start
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			st_r <= IDLE;
			cnt_r <= W;
			bitn_r <= 3'h0;
			sh_r <= 8'h00;
			hdr_r <= 1'b1;
			txmode_r <= 1'b0;
			tbit_r <= 1'b0;
			LINK.tgt_o <= 1'b1;
			LINK.tgt_oe <= 1'b0;
			CMD_VALID <= 1'b0;
			CMD_CODE <= 8'h00;
			CMD_REJECT <= 1'b0;
			CMD_ABORT <= 1'b0;
			RX_VALID <= 1'b0;
			RX_BYTE <= 8'h00;
		end else begin
			CMD_VALID <= 1'b0;
			CMD_REJECT <= 1'b0;
			CMD_ABORT <= 1'b0;
			RX_VALID <= 1'b0;
			// abort drops framing only, no memory/mode change
			if (timeout_hit && !hdr_r) begin
				hdr_r <= 1'b1;
				bitn_r <= 3'h0;
				txmode_r <= 1'b0;
				CMD_ABORT <= 1'b1;
			end
			unique case (st_r)
			IDLE: begin
				LINK.tgt_oe <= 1'b0;
				if (fall) begin
					cnt_r <= W;
					tbit_r <= sh_r[7];
					st_r <= txmode_r ? TXBIT : RXBIT;
					// take the low over before the host lets go
					if (txmode_r && !sh_r[7]) begin
						LINK.tgt_o <= 1'b0;
						LINK.tgt_oe <= 1'b1;
					end
				end
			end
			RXBIT: if (tick) begin
				cnt_r <= cnt_r + 10'h001;
				if (cnt_r == 10'(swd_pkg::SAMPLE_CYCLE - 1)) begin
					sh_r <= rx_next;
					bitn_r <= bitn_r + 3'h1;
					if (bitn_r == 3'h7) begin
						if (hdr_r) begin
							CMD_CODE <= rx_next;
							// halted-only group
							if (!rx_next[swd_pkg::HALT_ONLY_BIT]
								&& !CPU_HALTED) begin
								CMD_REJECT <= 1'b1;
							end else begin
								CMD_VALID <= 1'b1;
								hdr_r <= 1'b0;
								// read-type codes: bits 6 and 5 set
								txmode_r <= rx_next[6] && rx_next[5];
								sh_r <= TX_BYTE;
							end
						end else begin
							RX_VALID <= 1'b1;
							RX_BYTE <= rx_next;
						end
					end
				end
				// a zero bit rises late; wait for it, else next edge is lost
				if (cnt_r >= 10'(swd_pkg::SAMPLE_CYCLE) && s2_r)
					st_r <= IDLE;
				else if (cnt_r == 10'(swd_pkg::SYNC_MIN_LOW))
					st_r <= SYNC_WAIT;
			end
			TXBIT: if (tick) begin
				cnt_r <= cnt_r + 10'h001;
				if (tbit_r && cnt_r == 10'(swd_pkg::ONE_PULSE_CYC - 1)) begin
					LINK.tgt_o <= 1'b1;
					LINK.tgt_oe <= 1'b1;
				end else if (!tbit_r
					&& cnt_r < 10'(swd_pkg::ZERO_LOW_CYC - 1)) begin
					LINK.tgt_o <= 1'b0;
					LINK.tgt_oe <= 1'b1;
				end else if (!tbit_r
					&& cnt_r == 10'(swd_pkg::ZERO_LOW_CYC - 1)) begin
					LINK.tgt_o <= 1'b1;
				end else begin
					LINK.tgt_oe <= 1'b0;
				end
				if (cnt_r == 10'(swd_pkg::ZERO_LOW_CYC + 1)) begin
					sh_r <= shift_in(sh_r, 1'b0);
					bitn_r <= bitn_r + 3'h1;
					if (bitn_r == 3'h7) begin
						hdr_r <= 1'b1;
						txmode_r <= 1'b0;
					end
					st_r <= IDLE;
				end
			end
			SYNC_WAIT: if (s2_r) begin
				cnt_r <= W;
				hdr_r <= 1'b1;
				bitn_r <= 3'h0;
				txmode_r <= 1'b0;
				st_r <= SYNC_RESP;
			end
			SYNC_RESP: if (tick) begin
				// low for a fixed count: host times it
				cnt_r <= cnt_r + 10'h001;
				// stay off the pin while the host's speedup settles
				if (cnt_r < 10'(swd_pkg::BIT_CYCLES)) begin
					LINK.tgt_oe <= 1'b0;
				end else if (cnt_r == 10'(swd_pkg::BIT_CYCLES)) begin
					LINK.tgt_o <= 1'b0;
					LINK.tgt_oe <= 1'b1;
				end else if (cnt_r == 10'(swd_pkg::BIT_CYCLES
					+ swd_pkg::SYNC_RESP_CYC)) begin
					LINK.tgt_o <= 1'b1;
				end else if (cnt_r > 10'(swd_pkg::BIT_CYCLES
					+ swd_pkg::SYNC_RESP_CYC)) begin
					LINK.tgt_oe <= 1'b0;
					st_r <= IDLE;
				end
			end
			endcase
		end
	end
endmodule

//--- verilog/swd_host.sv
// host end: sends and receives single bits, sync and reset strap
// assumes target runs at the same nominal rate as this clock
module swd_host (
	input  wire logic CLK_SYS,
	input  wire logic RST,
	swd_link_if.host LINK,
	input  wire logic REQ_VALID,
	input  wire logic REQ_DIR_RX,
	input  wire logic REQ_BIT,
	input  wire logic REQ_SYNC,
	input  wire logic REQ_STRAP,
	output logic      REQ_READY,
	output logic      RSP_VALID,
	output logic      RSP_BIT,
	output logic [9:0] SYNC_LEN
);
	typedef enum {H_IDLE, H_BIT, H_SYNC, H_MEAS, H_STRAP} swdh_state_type;
	swdh_state_type st_r;
	logic       s1_r, s2_r, rx_r, val_r;
	logic [9:0] cnt_r;
	////////////////////////////////////////////////////////////////
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
		end else begin
			s1_r <= LINK.pin;
			s2_r <= s1_r;
		end
	end
	////////////////////////////////////////////////////////////////
	// spacing of one bit period also covers delay slots
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			st_r <= H_IDLE;
			cnt_r <= 10'h000;
			rx_r <= 1'b0;
			val_r <= 1'b0;
			LINK.host_o <= 1'b1;
			LINK.host_oe <= 1'b0;
			LINK.host_reset <= 1'b0;
			REQ_READY <= 1'b0;
			RSP_VALID <= 1'b0;
			RSP_BIT <= 1'b0;
			SYNC_LEN <= 10'h000;
		end else begin
			RSP_VALID <= 1'b0;
			cnt_r <= cnt_r + 10'h001;
			unique case (st_r)
			H_IDLE: begin
				REQ_READY <= 1'b1;
				cnt_r <= 10'h000;
				if (REQ_READY && (REQ_VALID || REQ_SYNC || REQ_STRAP)) begin
					REQ_READY <= 1'b0;
					LINK.host_o <= 1'b0;
					LINK.host_oe <= 1'b1;
					rx_r <= REQ_DIR_RX;
					val_r <= REQ_BIT;
					LINK.host_reset <= REQ_STRAP;
					st_r <= REQ_STRAP ? H_STRAP
						: REQ_SYNC ? H_SYNC : H_BIT;
				end
			end
			H_BIT: begin
				// release before target pulse
				if (rx_r && cnt_r == 10'(swd_pkg::HOST_LOW_CYC + 1))
					LINK.host_oe <= 1'b0;
				if (!rx_r && cnt_r == 10'h003)
					LINK.host_o <= val_r; // driven high speedup
				if (rx_r && cnt_r == 10'(swd_pkg::HOST_SAMPLE + 2)) begin
					RSP_VALID <= 1'b1;
					RSP_BIT <= s2_r;
				end
				if (!rx_r && cnt_r == 10'(swd_pkg::ZERO_LOW_CYC + 1)) begin
					LINK.host_o <= 1'b1;
				end
				if (cnt_r == 10'(swd_pkg::BIT_CYCLES + 3)) begin
					LINK.host_oe <= 1'b0;
					st_r <= H_IDLE;
				end
			end
			H_SYNC: begin
				// long low then speedup high
				if (cnt_r == 10'(swd_pkg::SYNC_MIN_LOW + 4))
					LINK.host_o <= 1'b1;
				if (cnt_r == 10'(swd_pkg::SYNC_MIN_LOW + 5)) begin
					LINK.host_oe <= 1'b0;
					cnt_r <= 10'h000;
					st_r <= H_MEAS;
				end
			end
			H_MEAS: begin
				if (!s2_r)
					SYNC_LEN <= SYNC_LEN + 10'h001;
				else if (SYNC_LEN != 10'h000) begin
					RSP_VALID <= 1'b1;
					st_r <= H_IDLE;
				end
				if (cnt_r == 10'h3ff)
					st_r <= H_IDLE;
				if (cnt_r == 10'h000)
					SYNC_LEN <= 10'h000;
			end
			H_STRAP: begin
				// reset released first, pin afterwards
				if (cnt_r == 10'h008)
					LINK.host_reset <= 1'b0;
				if (cnt_r == 10'h010) begin
					LINK.host_oe <= 1'b0;
					st_r <= H_IDLE;
				end
			end
			endcase
		end
	end
endmodule

//--- testbench/swd_link_monitor.sv
// checker for the wire between both ends of the debug link
// assumes one clock for both ends and the resolved pin of the interface
module swd_link_monitor (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic tgt_o,
	input wire logic tgt_oe,
	input wire logic host_o,
	input wire logic host_oe,
	input wire logic pin,
	input wire logic host_reset
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	wire t_hi = tgt_oe && tgt_o;
	wire t_lo = tgt_oe && !tgt_o;
	////////////////////////////////////////////////////////////////////////
	chk_no_clash: assert property (!(t_hi && host_oe && !host_o))
		else $error("both ends fight on the pin");
	chk_pin_pullup: assert property (!tgt_oe && !host_oe |-> pin)
		else $error("undriven pin not high");
	chk_low_two: assert property ($fell(pin) |-> !pin ##1 !pin)
		else $error("bit start low too short");
	chk_bit_spacing: assert property (
		$fell(pin) |-> ##1 (!$fell(pin))[*8])
		else $error("bit starts too close");
	chk_pulse_brief: assert property (
		$rose(t_hi) |-> ##[1:3] !t_hi)
		else $error("speedup pulse too long");
	chk_host_release: assert property ($rose(t_hi) |-> !host_oe)
		else $error("host still drives at speedup");
	chk_zero_low: assert property ($rose(t_lo) |-> t_lo[*8])
		else $error("zero low time too short");
	chk_zero_speedup: assert property (
		$fell(t_lo) |-> ##[0:1] t_hi)
		else $error("no speedup after zero");
	////////////////////////////////////////////////////////////////////////
	cover property ($rose(t_hi));
	cover property ($rose(t_lo));
	cover property ($fell(host_reset));
endmodule

//--- testbench/single_wire_debug_link_test.sv
// bench joining host and target ends through one link interface
// assumes the host end keeps the nominal bit rate of the target
module single_wire_debug_link_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, alt = 0, dsel = 0, halt = 0;
	logic rv = 0, rx = 0, rb = 0, rs = 0, rt = 0;
	logic [7:0] txb = 8'h00;
	logic rdy, rsv, rsb, bh, cv, crj, cab, xv;
	logic [7:0] cc, xb;
	logic [9:0] sl;
	int fails = 0, checks_done = 0, n_cmd = 0, n_rej = 0, n_ab = 0, n_rx = 0;
	swd_link_if lnk();
	swd_target swd_target_i (.CLK_SYS(clk), .RST(rst), .LINK(lnk.target),
		.ALT_TICK(alt), .DEBUG_CLOCK_SELECT(dsel), .CPU_HALTED(halt),
		.TX_BYTE(txb), .BOOT_HALTED(bh), .CMD_VALID(cv), .CMD_CODE(cc),
		.CMD_REJECT(crj), .CMD_ABORT(cab), .RX_VALID(xv), .RX_BYTE(xb));
	swd_host swd_host_i (.CLK_SYS(clk), .RST(rst), .LINK(lnk.host),
		.REQ_VALID(rv), .REQ_DIR_RX(rx), .REQ_BIT(rb), .REQ_SYNC(rs),
		.REQ_STRAP(rt), .REQ_READY(rdy), .RSP_VALID(rsv), .RSP_BIT(rsb),
		.SYNC_LEN(sl));
	swd_link_monitor swd_link_monitor_i (.CLK_SYS(clk), .RST(rst),
		.tgt_o(lnk.tgt_o), .tgt_oe(lnk.tgt_oe), .host_o(lnk.host_o),
		.host_oe(lnk.host_oe), .pin(lnk.pin), .host_reset(lnk.host_reset));
	always #25 clk = ~clk;
	// pulses are counted so a short one is never missed between polls
	always @(posedge clk) begin
		n_cmd += int'(cv === 1'b1);
		n_rej += int'(crj === 1'b1);
		n_ab += int'(cab === 1'b1);
		n_rx += int'(xv === 1'b1);
	end
	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wt(input bit rsp);
		int i;
		i = 0;
		while (rsp ? rsv !== 1'b1 : rdy !== 1'b1) begin
			@(negedge clk);
			i++;
			if (i > 800) begin
				fails++;
				$display("[ERR] %0t host hang", $time);
				end_of_test;
			end
		end
	endtask
	// one host request, held until the edge that takes it
	task automatic go(input logic d, input logic b, input logic s,
		input logic t);
		wt(0);
		rv = 1; rx = d; rb = b; rs = s; rt = t;
		@(negedge clk);
		rv = 0; rs = 0; rt = 0;
		if (d) wt(1);
	endtask
	task automatic byte_out(input logic [7:0] v);
		for (int k = 7; k >= 0; k--) go(0, v[k], 0, 0);
		idle(20);
	endtask
	task automatic byte_in(input logic [7:0] e);
		logic [7:0] g;
		for (int k = 7; k >= 0; k--) begin
			go(1, 0, 0, 0);
			g[k] = rsb;
		end
		cmp(10'(g), 10'(e));
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_cmds;
		cmp(10'(bh), 10'h0000);
		byte_out(8'h48);
		cmp(10'(n_rej), 10'h0001);
		cmp(10'(n_cmd), 10'h0000);
		halt = 1;
		byte_out(8'h48);
		cmp(10'(n_cmd), 10'h0001);
		cmp(10'(cc), 10'h0048);
		byte_out(8'h5A);
		cmp(10'(xb), 10'h005A);
		cmp(10'(n_rx), 10'h0001);
		$display("t_cmds done");
	endtask
	task automatic t_timeout;
		idle(470);
		cmp(10'(n_ab), 10'h0000);
		idle(60);
		cmp(10'(n_ab), 10'h0001);
		halt = 0;
		byte_out(8'hC0);
		cmp(10'(cc), 10'h00C0);
		// alt source frozen: no ticks, so no timeout may fire
		dsel = 1;
		idle(600);
		cmp(10'(n_ab), 10'h0001);
		alt = 1;
		idle(600);
		cmp(10'(n_ab), 10'h0002);
		dsel = 0;
		$display("t_timeout done");
	endtask
	task automatic t_read;
		txb = 8'hA5;
		byte_out(8'hE0);
		cmp(10'(cc), 10'h00E0);
		byte_in(8'hA5);
		idle(600);
		$display("t_read done");
	endtask
	task automatic t_sync_strap;
		go(0, 0, 1, 0);
		wt(0);
		cmp(sl, 10'(swd_pkg::SYNC_RESP_CYC));
		go(0, 0, 0, 1);
		wt(0);
		idle(4);
		cmp(10'(bh), 10'h0001);
		$display("t_sync_strap done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		idle(16);
		rst = 0;
		idle(2);
		t_cmds;
		t_timeout;
		t_read;
		t_sync_strap;
		end_of_test;
	end
endmodule
